// File: core/irqack_pkg.sv
// Purpose: constants shared by the interrupt request and acknowledge block
// Assumes: single clock domain, APB register access
// Notes:
`default_nettype none
package irqack_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] irqack_off_status  = 8'h00;
    localparam logic [7:0] irqack_off_mask    = 8'h04;
    localparam logic [7:0] irqack_off_unitmsk = 8'h08;
    localparam logic [7:0] irqack_off_coremsk = 8'h0c;
    localparam logic [7:0] irqack_off_autovec = 8'h10;
    localparam logic [7:0] irqack_off_vector  = 8'h14;
    localparam logic [7:0] irqack_off_state   = 8'h18;
    // status bits
    localparam int irqack_st_taken = 0;
    localparam int irqack_st_ack   = 1;
    localparam int irqack_st_nmi   = 2;
    localparam int irqack_st_w     = 3;
    // reset values
    localparam logic [2:0] irqack_coremsk_rst = 3'h7;
    localparam logic [6:0] irqack_unitmsk_rst = 7'h00;
    // acknowledge cycle encodings
    localparam logic [1:0]  irqack_type_ack  = 2'h3;
    localparam logic [26:0] irqack_addr_high = 27'h7ffffff;
    localparam logic [1:0]  irqack_addr_low  = 2'h0;
    localparam logic [7:0]  irqack_autovec_base = 8'h18;
    localparam logic [2:0]  irqack_lvl_nmi   = 3'h7;
endpackage : irqack_pkg
`default_nettype wire

// File: core/irqack_sync.sv
// Purpose: double-flop synchroniser and two-sample stability filter
// Assumes: request lines asynchronous to clk_sys
// Notes: first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module irqack_sync #(
    parameter int W = 3
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] stable_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] stable_reg;
    wire  logic   same;
    assign same = (s2_reg == s3_reg);
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s1_reg     <= '0;
            s2_reg     <= '0;
            s3_reg     <= '0;
            stable_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (same) begin
                stable_reg <= s3_reg;
            end
        end
    end
    assign stable_out = stable_reg;
endmodule : irqack_sync
`default_nettype wire

// File: core/irqack_top.sv
// Purpose: interrupt recognition and acknowledge bus cycle generation
// Assumes: core gives instruction boundary and handler retire pulses
// Notes: request level pins are active low encoded
`timescale 1ns/1ps
`default_nettype none
module irqack_top (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic        irq_out,
    // request pins, active low level code
    input  wire logic [2:0]  interrupt_request_lines_n,
    // core side
    input  wire logic        insn_boundary,
    input  wire logic        insn_retire,
    input  wire logic        higher_exc_pending,
    input  wire logic        int_source_internal,
    output var  logic        exc_take,
    output var  logic [7:0]  exc_vector,
    output var  logic [2:0]  exc_level,
    // external bus acknowledge cycle
    output var  logic        address_strobe_n,
    output var  logic [31:0] bus_addr,
    output var  logic [1:0]  transfer_type,
    output var  logic [2:0]  transfer_modifier,
    output var  logic        bus_rnw,
    input  wire logic        transfer_acknowledge_n,
    input  wire logic [31:0] bus_rdata
);
    typedef enum logic [1:0] {irqack_idle, irqack_bus, irqack_handler} irqack_state_t;

    irqack_state_t state_reg;
    irqack_state_t state_next;
    logic [2:0]  level;
    logic [2:0]  coremsk_reg;
    logic [6:0]  unitmsk_reg;
    logic [6:0]  autovec_reg;
    logic        autovec_visible_reg;
    logic [3:0]  status_reg;
    logic [3:0]  mask_reg;
    logic [2:0]  prev_level_reg;
    logic        nmi_pend_reg;
    logic [2:0]  lvl_reg;
    logic        autovec_cur_reg;
    logic [7:0]  vector_reg;
    logic        take_reg;
    logic [1:0]  xack_sync_reg;
    logic [31:0] prdata_reg;

    // ****************************************
    // request filtering
    // ****************************************
    irqack_sync #(.W(3)) u_sync (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .async_in   (~interrupt_request_lines_n),
        .stable_out (level)
    );

    function automatic logic [6:0] lvl_bit(input logic [2:0] l);
        lvl_bit = (l == 3'h0) ? 7'h00 : 7'(7'h01 << (l - 3'h1));
    endfunction : lvl_bit

    wire logic unit_pass;
    wire logic nmi_rise;
    wire logic core_pass;
    wire logic can_take;
    wire logic xack_seen;
    wire logic ext_cycle;
    wire logic wr;
    wire logic rd;
    wire logic lowered;
    assign unit_pass = (level == irqack_pkg::irqack_lvl_nmi) ||
                       ((lvl_bit(level) & unitmsk_reg) == 7'h00);
    assign nmi_rise  = (level == irqack_pkg::irqack_lvl_nmi) &&
                       (prev_level_reg != irqack_pkg::irqack_lvl_nmi);
    assign lowered   = wr && (paddr == irqack_pkg::irqack_off_coremsk) &&
                       (pwdata[2:0] != irqack_pkg::irqack_lvl_nmi) &&
                       (level == irqack_pkg::irqack_lvl_nmi);
    assign core_pass = (level != 3'h0) && unit_pass && (level > coremsk_reg) &&
                       (level != irqack_pkg::irqack_lvl_nmi);
    assign can_take  = insn_boundary && !higher_exc_pending &&
                       (state_reg == irqack_idle) && (core_pass || nmi_pend_reg);
    assign xack_seen = !xack_sync_reg[1];
    assign ext_cycle = int_source_internal ? !autovec_cur_reg :
                       (!autovec_cur_reg || !autovec_visible_reg);
    assign wr        = psel && penable && pwrite;
    assign rd        = psel && penable && !pwrite;

    // ****************************************
    // sequencing
    // ****************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            irqack_idle: begin
                if (can_take) begin
                    state_next = irqack_bus;
                end
            end
            irqack_bus: begin
                if (!ext_cycle || xack_seen) begin
                    state_next = irqack_handler;
                end
            end
            irqack_handler: begin
                if (insn_retire) begin
                    state_next = irqack_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_reg      <= irqack_idle;
            prev_level_reg <= 3'h0;
            nmi_pend_reg   <= 1'b0;
            lvl_reg        <= 3'h0;
            autovec_cur_reg <= 1'b0;
            vector_reg     <= 8'h00;
            take_reg       <= 1'b0;
            xack_sync_reg  <= 2'h3;
        end else begin
            state_reg      <= state_next;
            prev_level_reg <= level;
            xack_sync_reg  <= {xack_sync_reg[0], transfer_acknowledge_n};
            take_reg       <= 1'b0;
            if (nmi_rise || lowered) begin
                nmi_pend_reg <= 1'b1;
            end else if (can_take && nmi_pend_reg) begin
                nmi_pend_reg <= 1'b0;
            end
            if (can_take) begin
                lvl_reg      <= nmi_pend_reg ? irqack_pkg::irqack_lvl_nmi : level;
                autovec_cur_reg <= autovec_reg[nmi_pend_reg ? 3'h6 : 3'(level - 3'h1)];
            end
            if (state_reg == irqack_bus && state_next == irqack_handler) begin
                take_reg <= 1'b1;
                if (autovec_cur_reg) begin
                    vector_reg <= 8'(irqack_pkg::irqack_autovec_base + {5'h00, lvl_reg});
                end else begin
                    vector_reg <= bus_rdata[31:24];
                end
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    wire logic [3:0] ev;
    assign ev = {lowered, nmi_rise, xack_seen && state_reg == irqack_bus, take_reg};

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            coremsk_reg      <= irqack_pkg::irqack_coremsk_rst;
            unitmsk_reg      <= irqack_pkg::irqack_unitmsk_rst;
            autovec_reg         <= 7'h00;
            autovec_visible_reg <= 1'b0;
            status_reg       <= 4'h0;
            mask_reg         <= 4'h0;
        end else begin
            if (wr && paddr == irqack_pkg::irqack_off_status) begin
                status_reg <= (status_reg & ~pwdata[3:0]) | ev;
            end else begin
                status_reg <= status_reg | ev;
            end
            if (wr && paddr == irqack_pkg::irqack_off_mask) begin
                mask_reg <= pwdata[3:0];
            end
            if (wr && paddr == irqack_pkg::irqack_off_unitmsk) begin
                unitmsk_reg <= {1'b0, pwdata[5:0]};
            end
            if (take_reg) begin
                coremsk_reg <= lvl_reg;
            end else if (wr && paddr == irqack_pkg::irqack_off_coremsk) begin
                coremsk_reg <= pwdata[2:0];
            end
            if (wr && paddr == irqack_pkg::irqack_off_autovec) begin
                autovec_reg         <= pwdata[6:0];
                autovec_visible_reg <= pwdata[8];
            end
        end
    end

    wire logic mapped;
    assign mapped = (paddr == irqack_pkg::irqack_off_status) || (paddr == irqack_pkg::irqack_off_mask) ||
                    (paddr == irqack_pkg::irqack_off_unitmsk) || (paddr == irqack_pkg::irqack_off_coremsk) ||
                    (paddr == irqack_pkg::irqack_off_autovec) || (paddr == irqack_pkg::irqack_off_vector) ||
                    (paddr == irqack_pkg::irqack_off_state);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            prdata_reg <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                irqack_pkg::irqack_off_status:  prdata_reg <= {28'h0, status_reg};
                irqack_pkg::irqack_off_mask:    prdata_reg <= {28'h0, mask_reg};
                irqack_pkg::irqack_off_unitmsk: prdata_reg <= {25'h0, unitmsk_reg};
                irqack_pkg::irqack_off_coremsk: prdata_reg <= {29'h0, coremsk_reg};
                irqack_pkg::irqack_off_autovec: prdata_reg <= {23'h0, autovec_visible_reg, 1'b0, autovec_reg};
                irqack_pkg::irqack_off_vector:  prdata_reg <= {24'h0, vector_reg};
                irqack_pkg::irqack_off_state:   prdata_reg <= {23'h0, state_reg, nmi_pend_reg, level, lvl_reg};
                default:                        prdata_reg <= 32'h0;
            endcase
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    wire logic bus_active;
    assign bus_active        = (state_reg == irqack_bus) && ext_cycle;
    assign prdata            = prdata_reg;
    assign pready            = 1'b1;
    assign pslverr           = psel && penable && !mapped;
    assign irq_out           = |(status_reg & mask_reg);
    assign exc_take          = take_reg;
    assign exc_vector        = vector_reg;
    assign exc_level         = lvl_reg;
    assign address_strobe_n  = !bus_active;
    assign bus_addr          = bus_active ? {irqack_pkg::irqack_addr_high, lvl_reg,
                                              irqack_pkg::irqack_addr_low} : 32'h0;
    assign transfer_type     = bus_active ? irqack_pkg::irqack_type_ack : 2'h0;
    assign transfer_modifier = bus_active ? lvl_reg : 3'h0;
    assign bus_rnw           = 1'b1;
endmodule : irqack_top
`default_nettype wire

// File: verification/irqack_sva.sv
// Purpose: checks on the acknowledge cycle and on exception taking
// Assumes: sees only ports of irqack_top
// Notes: bound to every irqack_top
`timescale 1ns/1ps
`default_nettype none
module irqack_sva (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        exc_take,
    input wire logic        insn_retire,
    input wire logic        address_strobe_n,
    input wire logic [31:0] bus_addr,
    input wire logic [1:0]  transfer_type,
    input wire logic [2:0]  transfer_modifier,
    input wire logic        bus_rnw,
    input wire logic        transfer_acknowledge_n
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic hold_q;
    always_ff @(posedge clk_sys) begin
        hold_q <= !nrst ? 1'b0 : (exc_take ? 1'b1 : (insn_retire ? 1'b0 : hold_q));
    end
    property p_ack_addr; !address_strobe_n |-> bus_addr == {27'h7ffffff, transfer_modifier, 2'h0}; endproperty
    property p_ack_type; !address_strobe_n |-> transfer_type == 2'h3 && bus_rnw && transfer_modifier != 3'h0; endproperty
    property p_idle_bus; address_strobe_n |-> bus_addr == 32'h0 && transfer_type == 2'h0; endproperty
    property p_ack_stable; !address_strobe_n && !$past(address_strobe_n) |-> $stable(bus_addr); endproperty
    property p_strobe_hold;
        !address_strobe_n && transfer_acknowledge_n && $past(transfer_acknowledge_n) |=> !address_strobe_n;
    endproperty
    property p_strobe_end; $fell(transfer_acknowledge_n) |-> ##[1:6] address_strobe_n; endproperty
    property p_take_pulse; exc_take |=> !exc_take; endproperty
    property p_hold_retire; hold_q && !insn_retire |-> !exc_take && address_strobe_n; endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("acknowledge address wrong");
    a_ack_type: assert property (p_ack_type) else $error("acknowledge type wrong");
    a_idle_bus: assert property (p_idle_bus) else $error("idle bus not zero");
    a_ack_stable: assert property (p_ack_stable) else $error("address moved in cycle");
    a_strobe_hold: assert property (p_strobe_hold) else $error("strobe ended early");
    a_strobe_end: assert property (p_strobe_end) else $error("strobe not ended");
    a_take_pulse: assert property (p_take_pulse) else $error("take not a pulse");
    a_hold_retire: assert property (p_hold_retire) else $error("interrupt before handler ran");
    c_ack: cover property ($fell(address_strobe_n));
    c_take: cover property (exc_take);
    c_nmi: cover property (!address_strobe_n && transfer_modifier == 3'h7);
endmodule : irqack_sva
bind irqack_top irqack_sva u_sva (.clk_sys(clk_sys), .nrst(nrst), .exc_take(exc_take), .insn_retire(insn_retire),
    .address_strobe_n(address_strobe_n), .bus_addr(bus_addr), .transfer_type(transfer_type),
    .transfer_modifier(transfer_modifier), .bus_rnw(bus_rnw), .transfer_acknowledge_n(transfer_acknowledge_n));
`default_nettype wire

// File: verification/irqack_resp.sv
// Purpose: vector responder on the acknowledge cycle
// Assumes: wait count set by bench
// Notes: data lines toggle when idle
`timescale 1ns/1ps
`default_nettype none
module irqack_resp (
    input  wire logic        clk_sys,
    input  wire logic [3:0]  wait_cyc,
    input  wire logic        address_strobe_n,
    input  wire logic [2:0]  transfer_modifier,
    output var  logic        transfer_acknowledge_n,
    output var  logic [31:0] bus_rdata
);
    logic [3:0] cnt;
    initial begin
        transfer_acknowledge_n = 1'b1;
        bus_rdata = 32'h0;
        cnt = 4'h0;
    end
    always @(posedge clk_sys) begin
        if (address_strobe_n) begin
            cnt <= 4'h0;
            transfer_acknowledge_n <= 1'b1;
            bus_rdata <= ~bus_rdata;
        end else if (cnt < wait_cyc) begin
            cnt <= cnt + 4'h1;
        end else begin
            transfer_acknowledge_n <= 1'b0;
            bus_rdata <= {5'h08, transfer_modifier, 24'h0};
        end
    end
endmodule : irqack_resp
`default_nettype wire

// File: verification/tb_interrupt_request_and_ack_cycle.sv
// Purpose: self-checking bench for irqack_top
// Assumes: responder vector is 0x40 plus level
// Notes: notes queued by drivers, popped by watcher
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_request_and_ack_cycle;
    // ****************************************
    // bench
    // ****************************************
    logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, irq_out, bnd, ret, hip, isrc;
    logic exc_take, strb_n, rnw, xack_n;
    logic [7:0] paddr, exc_vector;
    logic [31:0] pwdata, prdata, baddr, rdata;
    logic [2:0] req_n, exc_level, tmod;
    logic [1:0] ttype;
    logic [3:0] wc;
    integer seed = 94425;
    int errors = 0, checked = 0, i;
    logic [31:0] rd_q[$], ex_q[$];
    logic er_q[$];
    irqack_top DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_out(irq_out),
        .interrupt_request_lines_n(req_n), .insn_boundary(bnd), .insn_retire(ret), .higher_exc_pending(hip),
        .int_source_internal(isrc), .exc_take(exc_take), .exc_vector(exc_vector), .exc_level(exc_level),
        .address_strobe_n(strb_n), .bus_addr(baddr), .transfer_type(ttype), .transfer_modifier(tmod),
        .bus_rnw(rnw), .transfer_acknowledge_n(xack_n), .bus_rdata(rdata));
    irqack_resp u_resp (.clk_sys(clk_sys), .wait_cyc(wc), .address_strobe_n(strb_n), .transfer_modifier(tmod),
        .transfer_acknowledge_n(xack_n), .bus_rdata(rdata));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task cmp(input logic [31:0] e, input logic [31:0] a);
        checked++;
        if (a !== e) begin
            errors++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : cmp
    task end_of_test;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        er_q.push_back(a > irqack_pkg::irqack_off_state || a[1:0] != 2'h0);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin errors++; end_of_test(); end
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task run(input logic [2:0] l, input logic tk, input logic [7:0] v, input logic sb, input logic drop);
        logic t, s;
        t = 1'b0; s = 1'b0;
        wc <= 4'($random(seed) & 3);
        if (tk) ex_q.push_back({21'h0, l, v});
        req_n <= ~l;
        for (int k = 0; k < 80 && !t; k++) begin
            @(posedge clk_sys);
            t = (exc_take === 1'b1);
            s = s | (strb_n === 1'b0);
        end
        if (drop) req_n <= 3'h7;
        cmp({30'h0, tk, sb}, {30'h0, t, s});
        @(posedge clk_sys) ret <= 1'b1;
        @(posedge clk_sys) ret <= 1'b0;
    endtask : run
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite) cmp(rd_q.pop_front(), prdata);
        if (psel && penable && pready) cmp({31'h0, er_q.pop_front()}, {31'h0, pslverr});
        if (exc_take === 1'b1) cmp(ex_q.size() ? ex_q.pop_front() : 32'hffffffff, {21'h0, exc_level, exc_vector});
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ret, hip, isrc, wc} = '0;
        nrst = 1'b0; bnd = 1'b1; req_n = 3'h7;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(irqack_pkg::irqack_off_coremsk, 32'h7);
        rd(irqack_pkg::irqack_off_unitmsk, 32'h0);
        rd(8'hfc, 32'h0);
        for (i = 1; i < 7; i++) begin
            apb(1'b1, irqack_pkg::irqack_off_coremsk, 32'h0);
            run(3'(i), 1'b1, 8'h40 + 8'(i), 1'b1, 1'b1);
        end
        apb(1'b1, irqack_pkg::irqack_off_coremsk, 32'h3);
        @(posedge clk_sys) req_n <= 3'h1;
        @(posedge clk_sys) req_n <= 3'h7;
        run(3'h3, 1'b0, 8'h0, 1'b0, 1'b1);
        run(3'h4, 1'b1, 8'h44, 1'b1, 1'b1);
        apb(1'b1, irqack_pkg::irqack_off_coremsk, 32'h6);
        apb(1'b1, irqack_pkg::irqack_off_unitmsk, 32'h10);
        apb(1'b1, irqack_pkg::irqack_off_coremsk, 32'h0);
        run(3'h5, 1'b0, 8'h0, 1'b0, 1'b1);
        apb(1'b1, irqack_pkg::irqack_off_unitmsk, 32'h0);
        hip <= 1'b1;
        run(3'h1, 1'b0, 8'h0, 1'b0, 1'b0);
        hip <= 1'b0;
        run(3'h1, 1'b1, 8'h41, 1'b1, 1'b1);
        apb(1'b1, irqack_pkg::irqack_off_unitmsk, 32'h40);
        run(3'h7, 1'b1, 8'h47, 1'b1, 1'b0);
        run(3'h7, 1'b0, 8'h0, 1'b0, 1'b0);
        apb(1'b1, irqack_pkg::irqack_off_coremsk, 32'h6);
        run(3'h7, 1'b1, 8'h47, 1'b1, 1'b1);
        rd(irqack_pkg::irqack_off_coremsk, 32'h7);
        run(3'h7, 1'b1, 8'h47, 1'b1, 1'b1);
        isrc <= 1'b1;
        apb(1'b1, irqack_pkg::irqack_off_autovec, 32'h2);
        apb(1'b1, irqack_pkg::irqack_off_coremsk, 32'h0);
        run(3'h2, 1'b1, 8'h1a, 1'b0, 1'b1);
        isrc <= 1'b0;
        apb(1'b1, irqack_pkg::irqack_off_autovec, 32'h102);
        apb(1'b1, irqack_pkg::irqack_off_coremsk, 32'h0);
        run(3'h2, 1'b1, 8'h1a, 1'b0, 1'b1);
        apb(1'b1, irqack_pkg::irqack_off_mask, 32'h1);
        @(posedge clk_sys);
        cmp(32'h1, {31'h0, irq_out});
        apb(1'b1, irqack_pkg::irqack_off_mask, 32'h0);
        @(posedge clk_sys);
        cmp(32'h0, {31'h0, irq_out});
        apb(1'b1, irqack_pkg::irqack_off_status, 32'hf);
        rd(irqack_pkg::irqack_off_status, 32'h0);
        repeat (2) @(posedge clk_sys);
        end_of_test();
    end
endmodule : tb_interrupt_request_and_ack_cycle
`default_nettype wire
